// ==== logic/tx_clk_pkg.sv ====
// constants, field layouts and carrier types for the transmit clock and frame sync generator
// assumes one 200 MHz system clock and a plain address/strobe register port
package tx_clk_pkg;

  // ==========================================================
  // clock
  localparam int unsigned CLK_PERIOD_NS = 5;              // system clock period

  // ==========================================================
  // register map
  localparam int unsigned ADDR_W        = 4;              // register port address width
  localparam logic [3:0]  OFS_FS_CTL    = 4'h0;           // tx_frame_sync_control
  localparam logic [3:0]  OFS_CK_CTL    = 4'h4;           // tx_bit_clock_control
  localparam logic [3:0]  OFS_STATUS    = 4'h8;           // generator status, read only

  // ==========================================================
  // field positions
  localparam int unsigned FS_MODE_LSB   = 7;              // frame_slot_mode low bit
  localparam int unsigned FS_MODE_MSB   = 15;             // frame_slot_mode high bit
  localparam int unsigned FS_WID_BIT    = 4;              // frame_sync_width_sel
  localparam int unsigned FS_SRC_BIT    = 1;              // frame_sync_source_sel
  localparam int unsigned FS_POL_BIT    = 0;              // frame_sync_polarity_sel
  localparam int unsigned CK_POL_BIT    = 7;              // bit_clock_polarity_sel
  localparam int unsigned CK_IND_BIT    = 6;              // independent_clocking_sel
  localparam int unsigned CK_SRC_BIT    = 5;              // bit_clock_source_sel
  localparam int unsigned CK_DIV_MSB    = 4;              // bit_clock_divider high bit
  localparam int unsigned ST_FS_BIT     = 0;              // status: frame sync level
  localparam int unsigned ST_BCLK_BIT   = 1;              // status: bit clock level
  localparam int unsigned ST_RUN_BIT    = 2;              // status: generator running
  localparam int unsigned ST_SLOT_LSB   = 16;             // status: current slot low bit
  localparam int unsigned ST_SLOT_MSB   = 24;             // status: current slot high bit

  // ==========================================================
  // slot mode codes
  localparam logic [8:0]  MODE_BURST    = 9'h000;         // burst, one word per sync
  localparam logic [8:0]  MODE_TDM_MIN  = 9'h002;         // smallest tdm slot count
  localparam logic [8:0]  MODE_TDM_MAX  = 9'h020;         // largest tdm slot count
  localparam logic [8:0]  MODE_DIT      = 9'h180;         // digital audio output mode
  localparam logic [8:0]  SLOTS_BURST   = 9'h001;         // frame length in burst
  localparam logic [8:0]  SLOTS_DIT     = 9'h180;         // 384 slots per frame

  // slot size: bits = 2 * (code + 1)
  localparam logic [5:0]  SLOT_BITS_ADD = 6'h02;          // offset in slot size formula
  localparam logic [5:0]  ONE_BIT       = 6'h01;          // single-bit sync width

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [8:0] slot_mode;                                // frame_slot_mode
    logic       width_sel;                                // frame_sync_width_sel
    logic       source_sel;                               // frame_sync_source_sel
    logic       polarity_sel;                             // frame_sync_polarity_sel
  } fs_ctl_s;

  typedef struct packed {
    logic       clk_pol;                                  // bit_clock_polarity_sel
    logic       indep;                                    // independent_clocking_sel
    logic       src;                                      // bit_clock_source_sel
    logic [4:0] div;                                      // bit_clock_divider
  } ck_ctl_s;

  localparam fs_ctl_s FS_CTL_RST = '0;                    // frame sync control after reset
  localparam ck_ctl_s CK_CTL_RST = '0;                    // bit clock control after reset

  // ==========================================================
  // synchroniser lanes
  localparam int unsigned SYNC_W   = 5;                   // pins passed through synchroniser
  localparam int unsigned IDX_HF   = 0;                   // high-frequency clock pin
  localparam int unsigned IDX_BCLK = 1;                   // bit clock pin
  localparam int unsigned IDX_FS   = 2;                   // frame sync pin
  localparam int unsigned IDX_RXB  = 3;                   // receive bit clock pin
  localparam int unsigned IDX_RXF  = 4;                   // receive frame sync pin

  // frame generator states
  typedef enum logic [1:0] {
    FG_IDLE = 2'b01,                                      // counters parked
    FG_RUN  = 2'b10                                       // frames being generated
  } fg_state_e;

endpackage

// ==== logic/pin_sync.sv ====
// two flip-flop synchroniser for a group of pin levels
// assumes the pins are asynchronous to clk_i and change slower than clk_i
`timescale 1ns/100ps

module pin_sync #(
  parameter int unsigned WIDTH = 1                        // number of lanes
) (
  input  wire logic             clk_i,                    // system clock
  input  wire logic             rst_i,                    // asynchronous system reset, active high
  input  wire logic [WIDTH-1:0] pin_i,                    // raw pin levels
  output logic      [WIDTH-1:0] sync_o                    // synchronised levels
);

  logic [WIDTH-1:0] meta_ff;                              // first stage, read only by sync_o

  // ==========================================================
  // two stages
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= '0;
      sync_o  <= '0;
    end else begin
      meta_ff <= pin_i;
      sync_o  <= meta_ff;
    end
  end

endmodule // pin_sync

// ==== logic/tx_clk_gen.sv ====
// transmit bit clock and frame sync generator with its two control registers
// assumes pins arrive asynchronous and toggle below a quarter of the 200 MHz clock
`timescale 1ns/100ps

module tx_clk_gen (
  input  wire logic                        clk_i,                     // system clock
  input  wire logic                        rst_i,                     // asynchronous system reset, active high
  // register port
  input  wire logic [tx_clk_pkg::ADDR_W-1:0] reg_addr_i,              // byte address
  input  wire logic [31:0]                 reg_wdata_i,               // write data
  input  wire logic                        reg_we_i,                  // write strobe
  input  wire logic                        reg_re_i,                  // read strobe
  output logic      [31:0]                 reg_rdata_o,               // read data, next cycle
  // slot size code from the format unit
  input  wire logic [3:0]                  slot_size_i,               // bits = 2*(code+1)
  // pins
  input  wire logic                        transmit_high_freq_clock_i, // high clock pin
  input  wire logic                        transmit_bit_clock_i,      // bit clock pin in
  output logic                             transmit_bit_clock_o,      // bit clock pin out
  output logic                             transmit_bit_clock_oe_o,   // bit clock drive enable
  input  wire logic                        transmit_frame_sync_i,     // frame sync pin in
  output logic                             transmit_frame_sync_o,     // frame sync pin out
  output logic                             transmit_frame_sync_oe_o,  // frame sync drive enable
  input  wire logic                        rx_bit_clock_pin_i,        // receive bit clock pin
  input  wire logic                        rx_frame_sync_pin_i,       // receive frame sync pin
  // to the serial sections
  output logic                             tx_shift_tick_o,           // transmit shift edge pulse
  output logic                             tx_frame_start_o,          // frame start pulse
  output logic                             tx_frame_sync_lvl_o,       // frame sync level
  output logic                             rx_bit_clock_o,            // clock for receive section
  output logic                             rx_frame_sync_o            // sync for receive section
);

  import tx_clk_pkg::*;

  // ==========================================================
  // declarations
  fs_ctl_s               fs_ctl_ff;                       // tx_frame_sync_control
  ck_ctl_s               ck_ctl_ff;                       // tx_bit_clock_control
  logic [SYNC_W-1:0]     pins_raw;                        // pins into synchroniser
  logic [SYNC_W-1:0]     pins_sync;                       // synchronised pins
  logic                  hf_prev_ff;                      // previous high clock level
  logic                  hf_rise;                         // high clock rising edge
  logic [4:0]            div_cnt_ff;                      // divider phase
  logic                  bclk_int_ff;                     // internally made bit clock
  logic                  bclk_lvl;                        // selected bit clock level
  logic                  bclk_prev_ff;                    // previous bit clock level
  logic                  bclk_rise;                       // bit clock rising edge
  logic                  bclk_fall;                       // bit clock falling edge
  logic                  shift_tick;                      // shift edge this cycle
  logic                  fs_ext_prev_ff;                  // previous external sync level
  logic                  ext_start;                       // external frame start
  fg_state_e             fg_state_ff;                     // generator state
  fg_state_e             nxt_fg_state;                    // next generator state
  logic [5:0]            bit_cnt_ff;                      // bit within slot
  logic [8:0]            slot_cnt_ff;                     // slot within frame
  logic [5:0]            slot_bits;                       // bits per slot
  logic [5:0]            sync_bits;                       // sync active length
  logic [8:0]            frame_slots;                     // slots per frame
  logic                  mode_ok;                         // slot mode is not reserved
  logic                  fs_active_ff;                    // internal sync active
  logic                  fs_pin_lvl;                      // internal sync at pin polarity
  logic                  int_start;                       // internal frame start
  logic [31:0]           nxt_rdata;                       // read mux

  // ==========================================================
  // pin synchroniser
  assign pins_raw = {rx_frame_sync_pin_i, rx_bit_clock_pin_i, transmit_frame_sync_i,
                     transmit_bit_clock_i, transmit_high_freq_clock_i};

  pin_sync #(
    .WIDTH (SYNC_W)
  ) u_pin_sync (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (pins_raw),
    .sync_o (pins_sync)
  );

  // ==========================================================
  // register writes
  // reserved bits dropped
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_ctl_ff <= FS_CTL_RST;
      ck_ctl_ff <= CK_CTL_RST;
    end else if (reg_we_i) begin
      // only documented fields are stored
      if (reg_addr_i == OFS_FS_CTL) begin
        fs_ctl_ff.slot_mode    <= reg_wdata_i[FS_MODE_MSB:FS_MODE_LSB];
        fs_ctl_ff.width_sel    <= reg_wdata_i[FS_WID_BIT];
        fs_ctl_ff.source_sel   <= reg_wdata_i[FS_SRC_BIT];
        fs_ctl_ff.polarity_sel <= reg_wdata_i[FS_POL_BIT];
      end
      if (reg_addr_i == OFS_CK_CTL) begin
        ck_ctl_ff.clk_pol <= reg_wdata_i[CK_POL_BIT];
        ck_ctl_ff.indep   <= reg_wdata_i[CK_IND_BIT];
        ck_ctl_ff.src     <= reg_wdata_i[CK_SRC_BIT];
        ck_ctl_ff.div     <= reg_wdata_i[CK_DIV_MSB:0];
      end
    end
  end

  // ==========================================================
  // register reads
  // reserved bits read zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (reg_addr_i)
      // frame sync control
      OFS_FS_CTL: begin
        nxt_rdata[FS_MODE_MSB:FS_MODE_LSB] = fs_ctl_ff.slot_mode;
        nxt_rdata[FS_WID_BIT]              = fs_ctl_ff.width_sel;
        nxt_rdata[FS_SRC_BIT]              = fs_ctl_ff.source_sel;
        nxt_rdata[FS_POL_BIT]              = fs_ctl_ff.polarity_sel;
      end
      // bit clock control
      OFS_CK_CTL: begin
        nxt_rdata[CK_POL_BIT]   = ck_ctl_ff.clk_pol;
        nxt_rdata[CK_IND_BIT]   = ck_ctl_ff.indep;
        nxt_rdata[CK_SRC_BIT]   = ck_ctl_ff.src;
        nxt_rdata[CK_DIV_MSB:0] = ck_ctl_ff.div;
      end
      // live generator state
      OFS_STATUS: begin
        nxt_rdata[ST_FS_BIT]               = tx_frame_sync_lvl_o;
        nxt_rdata[ST_BCLK_BIT]             = bclk_lvl;
        nxt_rdata[ST_RUN_BIT]              = (fg_state_ff == FG_RUN);
        nxt_rdata[ST_SLOT_MSB:ST_SLOT_LSB] = slot_cnt_ff;
      end
      // unmapped reads zero
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  // read data stand one cycle after the strobe only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_re_i) begin
      reg_rdata_o <= nxt_rdata;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // bit clock divider
  assign hf_rise = pins_sync[IDX_HF] & ~hf_prev_ff;

  // phase counter runs on high clock rising edges
  // divide by field plus one
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hf_prev_ff <= 1'b0;
      div_cnt_ff <= 5'h00;
    end else begin
      hf_prev_ff <= pins_sync[IDX_HF];
      if (hf_rise) begin
        div_cnt_ff <= (div_cnt_ff >= ck_ctl_ff.div) ? 5'h00 : div_cnt_ff + 5'h01;
      end
    end
  end

  // divided level: high in the first half of each period
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bclk_int_ff <= 1'b0;
    end else if (ck_ctl_ff.div == 5'h00) begin
      bclk_int_ff <= pins_sync[IDX_HF];
    end else begin
      bclk_int_ff <= (div_cnt_ff <= (ck_ctl_ff.div >> 1));
    end
  end

  // ==========================================================
  // bit clock selection and edges
  // pin or divider
  assign bclk_lvl   = ck_ctl_ff.src ? bclk_int_ff : pins_sync[IDX_BCLK];
  assign bclk_rise  = bclk_lvl & ~bclk_prev_ff;
  assign bclk_fall  = ~bclk_lvl & bclk_prev_ff;
  assign shift_tick = ck_ctl_ff.clk_pol ? bclk_fall : bclk_rise;

  // edge history and pin drive
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bclk_prev_ff            <= 1'b0;
      tx_shift_tick_o         <= 1'b0;
      transmit_bit_clock_o    <= 1'b0;
      transmit_bit_clock_oe_o <= 1'b0;
    end else begin
      bclk_prev_ff            <= bclk_lvl;
      tx_shift_tick_o         <= shift_tick;
      transmit_bit_clock_o    <= bclk_int_ff;
      transmit_bit_clock_oe_o <= ck_ctl_ff.src;
    end
  end

  // ==========================================================
  // frame geometry
  // slot count from mode
  always_comb begin
    mode_ok     = 1'b1;
    frame_slots = SLOTS_BURST;
    if (fs_ctl_ff.slot_mode == MODE_BURST) begin
      frame_slots = SLOTS_BURST;
    end else if (fs_ctl_ff.slot_mode >= MODE_TDM_MIN && fs_ctl_ff.slot_mode <= MODE_TDM_MAX) begin
      frame_slots = fs_ctl_ff.slot_mode;
    end else if (fs_ctl_ff.slot_mode == MODE_DIT) begin
      frame_slots = SLOTS_DIT;
    end else begin
      // reserved codes park the generator
      mode_ok = 1'b0;
    end
  end

  assign slot_bits = {1'b0, slot_size_i, 1'b0} + SLOT_BITS_ADD;
  assign sync_bits = fs_ctl_ff.width_sel ? slot_bits : ONE_BIT;

  // ==========================================================
  // frame generator state
  always_comb begin
    nxt_fg_state = fg_state_ff;
    unique case (fg_state_ff)
      // wait for internal source and legal mode
      FG_IDLE: if (fs_ctl_ff.source_sel && mode_ok) nxt_fg_state = FG_RUN;
      // stop as soon as either is withdrawn
      FG_RUN:  if (!fs_ctl_ff.source_sel || !mode_ok) nxt_fg_state = FG_IDLE;
      default: nxt_fg_state = FG_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fg_state_ff <= FG_IDLE;
    end else begin
      fg_state_ff <= nxt_fg_state;
    end
  end

  // ==========================================================
  // bit and slot counters, one step per shift edge
  assign int_start = (fg_state_ff == FG_RUN) && shift_tick &&
                     (bit_cnt_ff == 6'h00) && (slot_cnt_ff == 9'h000);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_ff  <= 6'h00;
      slot_cnt_ff <= 9'h000;
    end else if (fg_state_ff != FG_RUN) begin
      bit_cnt_ff  <= 6'h00;
      slot_cnt_ff <= 9'h000;
    end else if (shift_tick) begin
      if (bit_cnt_ff >= slot_bits - ONE_BIT) begin
        bit_cnt_ff  <= 6'h00;
        slot_cnt_ff <= (slot_cnt_ff >= frame_slots - 9'h001) ? 9'h000 : slot_cnt_ff + 9'h001;
      end else begin
        bit_cnt_ff <= bit_cnt_ff + 6'h01;
      end
    end
  end

  // sync active from the first bit of slot zero
  // held for sync_bits periods
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_active_ff <= 1'b0;
    end else if (fg_state_ff != FG_RUN) begin
      fs_active_ff <= 1'b0;
    end else if (shift_tick) begin
      fs_active_ff <= (slot_cnt_ff == 9'h000) && (bit_cnt_ff < sync_bits);
    end
  end

  assign fs_pin_lvl = fs_ctl_ff.polarity_sel ? ~fs_active_ff : fs_active_ff;

  // ==========================================================
  // external frame start detection
  // start edge by polarity
  assign ext_start = fs_ctl_ff.polarity_sel ? (~pins_sync[IDX_FS] & fs_ext_prev_ff)
                                            : (pins_sync[IDX_FS] & ~fs_ext_prev_ff);

  // ==========================================================
  // frame sync outputs
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fs_ext_prev_ff           <= 1'b0;
      transmit_frame_sync_o    <= 1'b0;
      transmit_frame_sync_oe_o <= 1'b0;
      tx_frame_start_o         <= 1'b0;
      tx_frame_sync_lvl_o      <= 1'b0;
    end else begin
      fs_ext_prev_ff           <= pins_sync[IDX_FS];
      transmit_frame_sync_o    <= fs_pin_lvl;
      transmit_frame_sync_oe_o <= fs_ctl_ff.source_sel;
      // start from own counter or pin
      tx_frame_start_o         <= fs_ctl_ff.source_sel ? int_start : ext_start;
      tx_frame_sync_lvl_o      <= fs_ctl_ff.source_sel ? fs_pin_lvl : pins_sync[IDX_FS];
    end
  end

  // ==========================================================
  // receive section clocking
  // shared or independent
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_bit_clock_o  <= 1'b0;
      rx_frame_sync_o <= 1'b0;
    end else if (ck_ctl_ff.indep) begin
      rx_bit_clock_o  <= pins_sync[IDX_RXB];
      rx_frame_sync_o <= pins_sync[IDX_RXF];
    end else begin
      rx_bit_clock_o  <= bclk_lvl;
      rx_frame_sync_o <= fs_ctl_ff.source_sel ? fs_pin_lvl : pins_sync[IDX_FS];
    end
  end

endmodule // tx_clk_gen

// ==== verif/tx_clk_gen_assertions.sv ====
// port checks for the transmit clock generator
// assumes one clock domain, bound onto tx_clk_gen
`timescale 1ns/100ps
module tx_clk_gen_assertions (
  input wire logic [tx_clk_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic [31:0]                   reg_wdata_i,
  input wire logic                          reg_we_i,
  input wire logic                          reg_re_i,
  input wire logic [31:0]                   reg_rdata_o,
  input wire logic                          transmit_bit_clock_oe_o,
  input wire logic                          transmit_frame_sync_oe_o,
  input wire logic                          tx_shift_tick_o,
  input wire logic                          tx_frame_start_o
);
  import tx_clk_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========================================================
  // write decodes
  logic ck_wr;
  logic fs_wr;
  logic fs_own;
  assign ck_wr = reg_we_i && reg_addr_i == OFS_CK_CTL;
  assign fs_wr = reg_we_i && reg_addr_i == OFS_FS_CTL;
  assign fs_own = tx_frame_start_o && transmit_frame_sync_oe_o;
  a_ck_oe_value: assert property (ck_wr ##1 !ck_wr |-> ##1 transmit_bit_clock_oe_o == $past(reg_wdata_i[5], 2))
    else $error("bit clock drive enable differs from written source");
  a_fs_oe_value: assert property (fs_wr ##1 !fs_wr |-> ##1 transmit_frame_sync_oe_o == $past(reg_wdata_i[1], 2))
    else $error("frame sync drive enable differs from written source");
  a_rdata_idle: assert property (!$past(reg_re_i) |-> reg_rdata_o == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_fs_rsvd_zero: assert property ($past(reg_re_i && reg_addr_i == OFS_FS_CTL) |-> !(|(reg_rdata_o & 32'hFFFF_006C)))
    else $error("frame sync control reserved bits set");
  a_ck_rsvd_zero: assert property ($past(reg_re_i && reg_addr_i == OFS_CK_CTL) |-> !(|reg_rdata_o[31:8]))
    else $error("bit clock control reserved bits set");
  a_tick_single: assert property (tx_shift_tick_o |=> !tx_shift_tick_o)
    else $error("shift tick longer than one cycle");
  a_start_on_tick: assert property (fs_own |-> tx_shift_tick_o)
    else $error("internal frame start without shift tick");
  a_start_spacing: assert property (fs_own |=> !tx_frame_start_o [*8])
    else $error("internal frames shorter than one slot");
  cover property (fs_own);
  cover property (tx_frame_start_o && !transmit_frame_sync_oe_o);
  cover property (ck_wr ##2 fs_wr);
endmodule // tx_clk_gen_assertions

bind tx_clk_gen tx_clk_gen_assertions u_chk (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
  .transmit_bit_clock_oe_o(transmit_bit_clock_oe_o), .transmit_frame_sync_oe_o(transmit_frame_sync_oe_o),
  .tx_shift_tick_o(tx_shift_tick_o), .tx_frame_start_o(tx_frame_start_o));

// ==== verif/codec_model.sv ====
// behavioural audio codec on the pins
// assumes the bench starts and stops its frames
`timescale 1ns/100ps
module codec_model #(
  parameter int HF_HALF  = 15,      // high clock half period, ns
  parameter int BCK_HALF = 40       // bit clock half period, ns
) (
  input  wire logic run_i,          // frames running
  input  wire logic pol_i,          // sync polarity
  output logic      hf_clk_o,       // master clock
  output logic      bck_o,          // bit clock
  output logic      fs_o,           // frame sync
  output logic      rx_bck_o,       // receive bit clock
  output logic      rx_fs_o         // receive sync
);
  int n = 0;                        // bit in frame
  initial begin
    hf_clk_o = 1'b0;
    bck_o = 1'b0;
    fs_o = 1'b0;
  end
  // master clock runs free
  always #HF_HALF hf_clk_o = ~hf_clk_o;
  always begin
    #BCK_HALF;
    if (run_i) begin
      bck_o = ~bck_o;
      if (!bck_o) begin
        n = (n + 1) % 16;
        fs_o = pol_i ^ (n == 0);
      end
    end
  end
  assign rx_bck_o = bck_o;
  assign rx_fs_o  = fs_o;
endmodule // codec_model

// ==== verif/testbench.sv ====
// self-checking bench for the transmit clock generator
// assumes codec_model on the pins, checker bound in
`timescale 1ns/100ps
module testbench;
  import tx_clk_pkg::*;
  logic clk_i = 0, rst_i = 1, we = 0, re = 0, run = 0, pol = 0;
  logic [ADDR_W-1:0] addr = '0;
  logic [31:0] wd = '0, rdata;
  logic [3:0] ss = 4'h3;
  logic hf, cbck, cfs, rbck, rfs, bck_o, bck_oe, fs_o, fs_oe, tick, fst, lvl, rxb, rxf;
  wire bck_w = bck_oe ? bck_o : cbck;
  wire fs_w = fs_oe ? fs_o : cfs;
  int fails = 0, check_count = 0, t, r, s, w, v, e;
  int dv[3] = '{32'h20, 32'h21, 32'hA4};
  int md[4] = '{0, 2, 32, 384};
  always #2.5 clk_i = ~clk_i;
  tx_clk_gen u_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wd), .reg_we_i(we),
    .reg_re_i(re), .reg_rdata_o(rdata), .slot_size_i(ss), .transmit_high_freq_clock_i(hf),
    .transmit_bit_clock_i(bck_w), .transmit_bit_clock_o(bck_o), .transmit_bit_clock_oe_o(bck_oe),
    .transmit_frame_sync_i(fs_w), .transmit_frame_sync_o(fs_o), .transmit_frame_sync_oe_o(fs_oe),
    .rx_bit_clock_pin_i(rbck), .rx_frame_sync_pin_i(rfs), .tx_shift_tick_o(tick),
    .tx_frame_start_o(fst), .tx_frame_sync_lvl_o(lvl), .rx_bit_clock_o(rxb), .rx_frame_sync_o(rxf));
  codec_model u_codec (.run_i(run), .pol_i(pol), .hf_clk_o(hf), .bck_o(cbck), .fs_o(cfs),
    .rx_bck_o(rbck), .rx_fs_o(rfs));
  // ==========================================================
  // bus and compare tasks
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a; wd <= d; we <= 1'b1;
    @(posedge clk_i);
    we <= 1'b0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic near(input int g, input int e);
    check_count++;
    if (g > e + 1 || g < e - 1) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr <= a; re <= 1'b1;
    @(posedge clk_i);
    re <= 1'b0;
    #1 cmp(rdata, e);
  endtask
  // counts ticks, receive clock rises, starts
  task automatic count(input int n);
    logic p;
    t = 0; r = 0; s = 0; p = rxb;
    v = 0;
    e = 0;
    repeat (n) begin
      @(posedge clk_i);
      #1 t += tick; r += rxb & !p; s += fst; p = rxb;
      // pin clock against shared receive clock, and level at each tick
      v += (bck_o !== rxb);
      e += tick & bck_o;
    end
  endtask
  // ticks and active ticks of one whole frame
  task automatic frame();
    int k;
    t = 0; w = 0; k = 0;
    v = 0;
    while (!fst && k < 40000) begin @(posedge clk_i); #1 k++; end
    do begin
      @(posedge clk_i);
      #1 t += tick; w += tick & lvl; k++;
      // receive sync and driven pin must track the sync level
      v += (lvl !== rxf) + (fs_oe & (lvl !== fs_o));
    end while (!fst && k < 40000);
  endtask
  task automatic final_report();
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(OFS_CK_CTL, 32'h0);
    wr(OFS_FS_CTL, 32'hFFFF_FFFF);
    wr(OFS_CK_CTL, 32'hFFFF_FFFF);
    wr(4'hC, 32'hFFFF_FFFF);
    rd(OFS_FS_CTL, 32'h0000_FF93);
    rd(OFS_CK_CTL, 32'h0000_00FF);
    rd(4'hC, 32'h0);
    cmp({bck_oe, fs_oe}, 32'h3);
    count(300);
    cmp(s, 32'h0);
    $display("test registers done");
    foreach (dv[i]) begin
      wr(OFS_CK_CTL, dv[i]);
      count(40);
      count(96 * ((dv[i] & 31) + 1));
      near(t, 16);
      near(r, t);
      cmp(v, 32'h0);
      cmp(e, dv[i][7] ? 0 : t);
    end
    wr(OFS_CK_CTL, 32'h60);
    run = 1;
    count(480);
    near(r, 30);
    run = 0;
    $display("test bit clock done");
    wr(OFS_CK_CTL, 32'h20);
    foreach (md[i]) begin
      wr(OFS_FS_CTL, md[i] << 7 | 32'h2);
      frame();
      cmp(t, md[i] == 0 ? 8 : md[i] * 8);
      cmp(w, 32'h1);
      cmp(v, 32'h0);
    end
    @(posedge clk_i);
    ss <= 4'hF;
    wr(OFS_FS_CTL, 32'h0000_0112);
    frame();
    cmp(w, 32'd32);
    $display("test frame generator done");
    wr(OFS_CK_CTL, 32'h0);
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      wr(OFS_FS_CTL, p);
      run = 1;
      frame();
      near(t, 16);
      cmp(fs_w, !pol);
    end
    run = 0;
    $display("test external sync done");
    final_report();
  end
  initial begin
    #(CLK_PERIOD_NS * 95000);
    fails++;
    final_report();
  end
endmodule // testbench
